/* File: hdl/isc_pkg.sv */
/*
 * Constants, state encodings and pad carrier for the two-wire bus controller.
 * Assumes a 40 MHz system clock and 32-bit register words on the bus.
 */
package isc_pkg;
	localparam int CLK_MHZ = 40;
	// Master quarter bit period, 100 kHz bus
	localparam int QTR_NS = 2500;
	localparam int QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] QTR_LD = 8'(QTR_CYC - 1);

	localparam logic [4:0] OFS_RCV = 5'h00;
	localparam logic [4:0] OFS_TRN = 5'h04;
	localparam logic [4:0] OFS_CON = 5'h08;
	localparam logic [4:0] OFS_STAT = 5'h0c;
	localparam logic [4:0] OFS_ADD = 5'h10;

	localparam int CB_EN = 15;
	localparam int CB_REL = 12;
	localparam int CB_ALL = 11;
	localparam int CB_A10 = 10;
	localparam int CB_SLW = 9;
	localparam int CB_GC = 7;
	localparam int CB_STR = 6;
	localparam int CB_ACKDT = 5;
	localparam int RQ_ACKEN = 4;
	localparam int RQ_RCEN = 3;
	localparam int RQ_PEN = 2;
	localparam int RQ_RSEN = 1;
	localparam int RQ_SEN = 0;

	localparam int SB_ACKSTAT = 15;
	localparam int SB_MASTER_TX_ACTIVE = 14;
	localparam int SB_ADD10 = 8;
	localparam int SB_IWCOL = 7;
	localparam int SB_OV = 6;
	localparam int SB_RW = 2;
	localparam int SB_RBF = 1;
	localparam int SB_TBF = 0;

	localparam logic [15:0] CON_RST = 16'h1000;
	localparam logic [7:0] TRN_RST = 8'hff;
	localparam logic [4:0] HDR10 = 5'h1e;
	localparam logic [7:0] GC_ADDR = 8'h00;

	typedef enum logic [4:0] {SL_IDLE = 5'h01, SL_ADDR = 5'h02, SL_ADDR2 = 5'h04,
		SL_RX = 5'h08, SL_TX = 5'h10} isc_sl_t;
	typedef enum logic [5:0] {M_IDLE = 6'h01, M_WAIT = 6'h02, M_START = 6'h04,
		M_RSTART = 6'h08, M_STOP = 6'h10, M_BYTE = 6'h20} isc_ms_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} isc_pad_t;
	localparam isc_pad_t PAD_RST = '0;
endpackage

/* File: hdl/isc_ctl.sv */
/*
 * Two-wire bus controller: slave with clock stretching, 7/10-bit addressing,
 * general call and accept-all, plus a master start/stop/byte engine.
 * Assumes an Avalon-MM master on sys_clk and open-drain pads resolved outside.
 */
// How it works
// - Tx ack with empty buffer clears release
// - Tx stretch ignores stretch_enable, both address widths
// - Buffer loaded before ninth fall: no stretch
// - Software may set scl_release in any cycle without a hardware clear
// - Rx with stretch_enable and full buffer stretches
// - Buffer read before ninth fall: no stretch
// - 10-bit address phase stretches, then per byte
// - Software clear waits for SCL falling edge
// - Hold SCL low until scl_release set
// - Without stretch_enable, writes clearing release ignored
// - Master and slave event flags
// - slew_control_disable turns off slope control
// - all_address_accept_enable accepts every address
// - general_call_enable also matches all-zeros write
// - General call loads buffer, master event
// - Addressed 10-bit slave: restart+read goes transmit
// - Master makes clocks, Start, Stop, Restart
// - Master transmits bytes, receives acknowledge
// - Master receives bytes, sends acknowledge
// - Transmit buffer write starts master shifting
// - master_tx_active while master transmits
// - Own address: ack, slave event, buffer untouched
module isc_ctl (
	input wire logic sys_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic [4:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic scl_i, // SCL line level
	input wire logic sda_i, // SDA line level
	output isc_pkg::isc_pad_t pad, // Pad drive and enables
	output logic slew_control_disable, // Slope control off
	output logic master_event_flag, // Master event pulse
	output logic slave_event_flag // Slave event pulse
);
	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		return a == o;
	endfunction

	logic [1:0] scl_sy, sda_sy;
	logic scl_d, sda_d, scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
	logic bus_ack_r, rd, wr_lo, wr_hi;
	logic [31:0] rd_mux;
	logic [15:0] con_r, con_rd, stat_rd;
	logic [9:0] add_r;
	logic [7:0] trn_r, rcv_r;
	logic tbf_r, rbf_r, iwcol_r, ov_r, rel_r, rel_nxt, scl_hold_r, en;
	isc_pkg::isc_sl_t sl_st;
	logic [3:0] sl_bcnt;
	logic [7:0] sl_sh;
	logic sl_sda_low, sl_loaded, sl_ack_rx, sl_pend_s, sl_pend_m, sl_rxd, sl_a10s;
	logic full_address_matched, add10_r, sl_rw;
	logic f8, f9, hdr_ok, own7, gc_hit, all_ok, sl_put, sl_ovf, sl_take, auto_clr;
	isc_pkg::isc_ms_t m_st;
	logic [7:0] m_tmr;
	logic [2:0] m_step;
	logic [3:0] m_bits;
	logic [8:0] m_out;
	logic [7:0] m_in, m_byte_r;
	logic [4:0] m_req;
	logic m_scl_low, m_sda_low, m_mtx, m_mrx, m_done_r, m_put_r, ackstat_r, m_stall, m_take;

	// Line inputs pass two flops; edges compare the second stage with a third flop
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_sy <= {scl_sy[0], scl_i};
			sda_sy <= {sda_sy[0], sda_i};
			scl_d <= scl_sy[1];
			sda_d <= sda_sy[1];
		end
	end
	assign scl_s = scl_sy[1];
	assign sda_s = sda_sy[1];
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
	assign en = con_r[isc_pkg::CB_EN];

	// One wait state on every access
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_r;
	assign rd = avs_read & bus_ack_r;
	assign wr_lo = avs_write & bus_ack_r & avs_byteenable[0];
	assign wr_hi = avs_write & bus_ack_r & avs_byteenable[1];
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bus_ack_r <= 1'b0;
			avs_readdata <= '0;
		end
		else
		begin
			bus_ack_r <= (avs_read | avs_write) & ~bus_ack_r;
			if (avs_read & ~bus_ack_r)
				avs_readdata <= rd_mux;
		end
	end

	assign con_rd = {con_r[15:13], rel_r, con_r[11:5], m_req};
	always_comb
	begin
		stat_rd = '0;
		stat_rd[isc_pkg::SB_ACKSTAT] = ackstat_r;
		stat_rd[isc_pkg::SB_MASTER_TX_ACTIVE] = (m_st == isc_pkg::M_BYTE) & m_mtx;
		stat_rd[isc_pkg::SB_ADD10] = add10_r;
		stat_rd[isc_pkg::SB_IWCOL] = iwcol_r;
		stat_rd[isc_pkg::SB_OV] = ov_r;
		stat_rd[isc_pkg::SB_RW] = sl_rw;
		stat_rd[isc_pkg::SB_RBF] = rbf_r;
		stat_rd[isc_pkg::SB_TBF] = tbf_r;
	end
	always_comb
	begin
		rd_mux = '0;
		if (hit(avs_address, isc_pkg::OFS_RCV))
			rd_mux[7:0] = rcv_r;
		else if (hit(avs_address, isc_pkg::OFS_TRN))
			rd_mux[7:0] = trn_r;
		else if (hit(avs_address, isc_pkg::OFS_CON))
			rd_mux[15:0] = con_rd;
		else if (hit(avs_address, isc_pkg::OFS_STAT))
			rd_mux[15:0] = stat_rd;
		else if (hit(avs_address, isc_pkg::OFS_ADD))
			rd_mux[9:0] = add_r;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			con_r <= isc_pkg::CON_RST;
			add_r <= '0;
		end
		else
		begin
			if (wr_lo & hit(avs_address, isc_pkg::OFS_CON))
				con_r[7:0] <= avs_writedata[7:0];
			if (wr_hi & hit(avs_address, isc_pkg::OFS_CON))
				con_r[15:8] <= avs_writedata[15:8];
			if (wr_lo & hit(avs_address, isc_pkg::OFS_ADD))
				add_r[7:0] <= avs_writedata[7:0];
			if (wr_hi & hit(avs_address, isc_pkg::OFS_ADD))
				add_r[9:8] <= avs_writedata[9:8];
		end
	end
	assign slew_control_disable = con_r[isc_pkg::CB_SLW];

	// Transmit buffer; a write while full is dropped and flagged
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			trn_r <= isc_pkg::TRN_RST;
			tbf_r <= 1'b0;
			iwcol_r <= 1'b0;
		end
		else
		begin
			if (wr_lo & hit(avs_address, isc_pkg::OFS_TRN))
			begin
				if (tbf_r)
					iwcol_r <= 1'b1;
				else
				begin
					trn_r <= avs_writedata[7:0];
					tbf_r <= 1'b1;
				end
			end
			else if (sl_take | m_take)
				tbf_r <= 1'b0;
			if (wr_lo & hit(avs_address, isc_pkg::OFS_STAT) & ~avs_writedata[isc_pkg::SB_IWCOL])
				iwcol_r <= 1'b0;
		end
	end

	// Receive buffer; a load wins over a clearing read
	assign sl_put = f8 & (((sl_st == isc_pkg::SL_RX) & ~rbf_r) | gc_hit);
	assign sl_ovf = f8 & (sl_st == isc_pkg::SL_RX) & rbf_r;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rcv_r <= '0;
			rbf_r <= 1'b0;
			ov_r <= 1'b0;
		end
		else
		begin
			if (sl_put)
			begin
				rcv_r <= sl_sh;
				rbf_r <= 1'b1;
			end
			else if (m_put_r)
			begin
				rcv_r <= m_byte_r;
				rbf_r <= 1'b1;
			end
			else if (rd & hit(avs_address, isc_pkg::OFS_RCV))
				rbf_r <= 1'b0;
			if (sl_ovf)
				ov_r <= 1'b1;
			else if (wr_lo & hit(avs_address, isc_pkg::OFS_STAT) & ~avs_writedata[isc_pkg::SB_OV])
				ov_r <= 1'b0;
		end
	end

	assign f8 = scl_fall & (sl_bcnt == 4'h8);
	assign f9 = scl_fall & (sl_bcnt == 4'h9);
	assign hdr_ok = (sl_sh[7:3] == isc_pkg::HDR10) & (sl_sh[2:1] == add_r[9:8]);
	assign own7 = sl_sh[7:1] == add_r[6:0];
	assign all_ok = con_r[isc_pkg::CB_ALL];
	assign gc_hit = con_r[isc_pkg::CB_GC] & (sl_sh == isc_pkg::GC_ADDR) & (sl_st == isc_pkg::SL_ADDR);
	assign sl_take = (sl_st == isc_pkg::SL_TX) & ~sl_loaded & tbf_r & (sl_bcnt == 4'h0) & ~scl_s;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sl_st <= isc_pkg::SL_IDLE;
			sl_bcnt <= '0;
			sl_sh <= '0;
			sl_sda_low <= 1'b0;
			sl_loaded <= 1'b0;
			sl_ack_rx <= 1'b0;
			sl_pend_s <= 1'b0;
			sl_pend_m <= 1'b0;
			sl_rxd <= 1'b0;
			sl_a10s <= 1'b0;
			sl_rw <= 1'b0;
			full_address_matched <= 1'b0;
			add10_r <= 1'b0;
		end
		else if (!en | stop_c)
		begin
			sl_st <= isc_pkg::SL_IDLE;
			sl_bcnt <= '0;
			sl_sda_low <= 1'b0;
			full_address_matched <= 1'b0;
		end
		else if (start_c)
		begin
			sl_st <= isc_pkg::SL_ADDR;
			sl_bcnt <= '0;
			sl_sda_low <= 1'b0;
		end
		else
		begin
			if (scl_rise & (sl_st != isc_pkg::SL_IDLE))
			begin
				if (sl_bcnt < 4'h8)
				begin
					sl_sh <= {sl_sh[6:0], sda_s};
					sl_bcnt <= sl_bcnt + 4'h1;
				end
				else if (sl_bcnt == 4'h8)
				begin
					sl_ack_rx <= ~sda_s;
					sl_bcnt <= 4'h9;
				end
			end
			if (f8)
			begin
				sl_rxd <= 1'b0;
				sl_a10s <= 1'b0;
				sl_pend_s <= 1'b1;
				sl_sda_low <= 1'b1;
				case (sl_st)
					isc_pkg::SL_ADDR:
					begin
						sl_rw <= sl_sh[0];
						if (gc_hit)
						begin
							sl_st <= isc_pkg::SL_RX;
							sl_pend_s <= 1'b0;
							sl_pend_m <= 1'b1;
						end
						else if (con_r[isc_pkg::CB_A10] & hdr_ok & sl_sh[0] & full_address_matched)
							sl_st <= isc_pkg::SL_TX;
						else if (con_r[isc_pkg::CB_A10] & hdr_ok & ~sl_sh[0])
						begin
							sl_st <= isc_pkg::SL_ADDR2;
							sl_a10s <= 1'b1;
						end
						else if ((~con_r[isc_pkg::CB_A10] & own7) | all_ok)
							sl_st <= sl_sh[0] ? isc_pkg::SL_TX : isc_pkg::SL_RX;
						else
						begin
							sl_st <= isc_pkg::SL_IDLE;
							sl_pend_s <= 1'b0;
							sl_sda_low <= 1'b0;
							add10_r <= 1'b0;
						end
					end
					isc_pkg::SL_ADDR2:
					begin
						if ((sl_sh == add_r[7:0]) | all_ok)
						begin
							sl_st <= isc_pkg::SL_RX;
							full_address_matched <= 1'b1;
							add10_r <= 1'b1;
							sl_a10s <= 1'b1;
						end
						else
						begin
							sl_st <= isc_pkg::SL_IDLE;
							sl_pend_s <= 1'b0;
							sl_sda_low <= 1'b0;
							full_address_matched <= 1'b0;
							add10_r <= 1'b0;
						end
					end
					isc_pkg::SL_RX:
					begin
						sl_sda_low <= ~rbf_r;
						sl_rxd <= 1'b1;
					end
					default:
						sl_sda_low <= 1'b0;
				endcase
			end
			else if (f9)
			begin
				sl_bcnt <= '0;
				sl_pend_s <= 1'b0;
				sl_pend_m <= 1'b0;
				sl_sda_low <= 1'b0;
				sl_loaded <= 1'b0;
				if ((sl_st == isc_pkg::SL_TX) & ~sl_ack_rx)
					sl_st <= isc_pkg::SL_IDLE;
			end
			else if (scl_fall & (sl_st == isc_pkg::SL_TX) & (sl_bcnt != 4'h0))
				sl_sda_low <= ~sl_sh[7];
			else if (sl_take)
			begin
				sl_sh <= trn_r;
				sl_sda_low <= ~trn_r[7];
				sl_loaded <= 1'b1;
			end
		end
	end

	// Stretch decision at the ninth falling edge; hardware clear beats a set
	assign auto_clr = en & f9 & (((sl_st == isc_pkg::SL_TX) & sl_ack_rx & ~tbf_r)
		| (con_r[isc_pkg::CB_STR] & ((sl_rxd & rbf_r) | sl_a10s)));
	always_comb
	begin
		rel_nxt = rel_r;
		if (auto_clr)
			rel_nxt = 1'b0;
		else if (wr_hi & hit(avs_address, isc_pkg::OFS_CON))
		begin
			if (avs_writedata[isc_pkg::CB_REL])
				rel_nxt = 1'b1;
			else if (con_r[isc_pkg::CB_STR])
				rel_nxt = 1'b0;
		end
	end
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rel_r <= 1'b1;
			scl_hold_r <= 1'b0;
		end
		else
		begin
			rel_r <= rel_nxt;
			// Pull only after a seen falling edge, never cutting a high phase
			scl_hold_r <= en & ~rel_nxt & (scl_hold_r | scl_fall);
		end
	end

	// Master engine: quarter-period steps, stalls while others hold SCL
	assign m_stall = ~scl_s & (((m_st == isc_pkg::M_RSTART) & (m_step == 3'h2))
		| ((m_st == isc_pkg::M_STOP) & (m_step == 3'h2)) | ((m_st == isc_pkg::M_BYTE) & (m_step == 3'h2)));
	assign m_take = (m_st == isc_pkg::M_WAIT) & ~m_req[isc_pkg::RQ_RSEN] & ~m_req[isc_pkg::RQ_PEN] & tbf_r;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			m_st <= isc_pkg::M_IDLE;
			m_tmr <= '0;
			m_step <= '0;
			m_bits <= '0;
			m_out <= '0;
			m_in <= '0;
			m_byte_r <= '0;
			m_req <= '0;
			m_scl_low <= 1'b0;
			m_sda_low <= 1'b0;
			m_mtx <= 1'b0;
			m_mrx <= 1'b0;
			m_done_r <= 1'b0;
			m_put_r <= 1'b0;
			ackstat_r <= 1'b0;
		end
		else
		begin
			m_done_r <= 1'b0;
			m_put_r <= 1'b0;
			if (wr_lo & hit(avs_address, isc_pkg::OFS_CON))
				m_req <= m_req | avs_writedata[4:0];
			if (!en)
			begin
				m_st <= isc_pkg::M_IDLE;
				m_req <= '0;
				m_scl_low <= 1'b0;
				m_sda_low <= 1'b0;
			end
			else
			case (m_st)
				isc_pkg::M_IDLE:
				begin
					m_tmr <= isc_pkg::QTR_LD;
					m_step <= '0;
					if (m_req[isc_pkg::RQ_SEN])
						m_st <= isc_pkg::M_START;
				end
				isc_pkg::M_WAIT:
				begin
					m_tmr <= isc_pkg::QTR_LD;
					m_step <= '0;
					if (m_req[isc_pkg::RQ_RSEN])
						m_st <= isc_pkg::M_RSTART;
					else if (m_req[isc_pkg::RQ_PEN])
						m_st <= isc_pkg::M_STOP;
					else if (m_take)
					begin
						m_st <= isc_pkg::M_BYTE;
						m_out <= {trn_r, 1'b1};
						m_bits <= 4'h9;
						m_mtx <= 1'b1;
					end
					else if (m_req[isc_pkg::RQ_RCEN] | m_req[isc_pkg::RQ_ACKEN])
					begin
						m_st <= isc_pkg::M_BYTE;
						m_mrx <= m_req[isc_pkg::RQ_RCEN];
						m_out <= m_req[isc_pkg::RQ_RCEN] ? 9'h1ff : {con_r[isc_pkg::CB_ACKDT], 8'hff};
						m_bits <= m_req[isc_pkg::RQ_RCEN] ? 4'h8 : 4'h1;
					end
				end
				default:
				begin
					if (m_tmr != 8'h00)
						m_tmr <= m_tmr - 8'h01;
					else if (!m_stall)
					begin
						m_tmr <= isc_pkg::QTR_LD;
						m_step <= m_step + 3'h1;
						case (m_st)
							isc_pkg::M_START:
								case (m_step)
									3'h0: m_sda_low <= 1'b1;
									3'h1: m_scl_low <= 1'b1;
									default:
									begin
										m_st <= isc_pkg::M_WAIT;
										m_done_r <= 1'b1;
										m_req[isc_pkg::RQ_SEN] <= 1'b0;
									end
								endcase
							isc_pkg::M_RSTART:
								case (m_step)
									3'h0: m_sda_low <= 1'b0;
									3'h1: m_scl_low <= 1'b0;
									3'h2: m_sda_low <= 1'b1;
									3'h3: m_scl_low <= 1'b1;
									default:
									begin
										m_st <= isc_pkg::M_WAIT;
										m_done_r <= 1'b1;
										m_req[isc_pkg::RQ_RSEN] <= 1'b0;
									end
								endcase
							isc_pkg::M_STOP:
								case (m_step)
									3'h0: m_sda_low <= 1'b1;
									3'h1: m_scl_low <= 1'b0;
									3'h2: m_sda_low <= 1'b0;
									default:
									begin
										m_st <= isc_pkg::M_IDLE;
										m_done_r <= 1'b1;
										m_req[isc_pkg::RQ_PEN] <= 1'b0;
									end
								endcase
							default:
								case (m_step)
									3'h0: m_sda_low <= ~m_out[8];
									3'h1: m_scl_low <= 1'b0;
									default:
									begin
										m_scl_low <= 1'b1;
										m_step <= '0;
										m_out <= {m_out[7:0], 1'b1};
										m_in <= {m_in[6:0], sda_s};
										m_bits <= m_bits - 4'h1;
										if (m_bits == 4'h1)
										begin
											m_st <= isc_pkg::M_WAIT;
											m_done_r <= 1'b1;
											m_sda_low <= 1'b0;
											m_mtx <= 1'b0;
											m_mrx <= 1'b0;
											m_req[isc_pkg::RQ_RCEN] <= 1'b0;
											m_req[isc_pkg::RQ_ACKEN] <= 1'b0;
											if (m_mtx)
												ackstat_r <= sda_s;
											if (m_mrx)
											begin
												m_put_r <= 1'b1;
												m_byte_r <= {m_in[6:0], sda_s};
											end
										end
									end
								endcase
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pad <= isc_pkg::PAD_RST;
			master_event_flag <= 1'b0;
			slave_event_flag <= 1'b0;
		end
		else
		begin
			pad.scl_oe <= m_scl_low | scl_hold_r;
			pad.sda_oe <= m_sda_low | sl_sda_low;
			pad.scl_o <= 1'b0;
			pad.sda_o <= 1'b0;
			master_event_flag <= m_done_r | (f9 & sl_pend_m);
			slave_event_flag <= f9 & sl_pend_s;
		end
	end

	a_tx_stretch: assert property (@(posedge sys_clk) disable iff (!nrst)
		en && f9 && sl_st == isc_pkg::SL_TX && sl_ack_rx && !tbf_r |=> !rel_r ##1 scl_hold_r)
		else $error("tx stretch missing");
	a_tx_nostr: assert property (@(posedge sys_clk) disable iff (!nrst)
		f9 && sl_st == isc_pkg::SL_TX && tbf_r && rel_r && !avs_write |=> rel_r)
		else $error("tx stretched with full buffer");
	a_rx_stretch: assert property (@(posedge sys_clk) disable iff (!nrst)
		en && f9 && sl_rxd && rbf_r && con_r[isc_pkg::CB_STR] |=> !rel_r)
		else $error("rx stretch missing");
	a_rel_ignore: assert property (@(posedge sys_clk) disable iff (!nrst)
		wr_hi && hit(avs_address, isc_pkg::OFS_CON) && !con_r[isc_pkg::CB_STR] && !auto_clr
		&& !avs_writedata[isc_pkg::CB_REL] |=> rel_r == $past(rel_r))
		else $error("release changed without stretch enable");
	a_rel_set: assert property (@(posedge sys_clk) disable iff (!nrst)
		wr_hi && hit(avs_address, isc_pkg::OFS_CON) && avs_writedata[isc_pkg::CB_REL] && !auto_clr |=> rel_r)
		else $error("release set lost");
	a_hold_sync: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(scl_hold_r) |-> $past(scl_fall) && !scl_d)
		else $error("hold without falling edge");
	a_hold_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
		scl_hold_r && en |=> pad.scl_oe && (scl_hold_r || rel_r))
		else $error("scl not held");
	a_gc_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		en && f8 && gc_hit |=> rbf_r && rcv_r == isc_pkg::GC_ADDR ##[1:600] master_event_flag)
		else $error("general call not handled");
	a_slv_event: assert property (@(posedge sys_clk) disable iff (!nrst)
		en && f9 && sl_pend_s |=> slave_event_flag)
		else $error("slave event missing");
	a_pad_low: assert property (@(posedge sys_clk) disable iff (!nrst)
		!pad.scl_o && !pad.sda_o)
		else $error("pad driven high");
endmodule // isc_ctl

/* File: sim/isc_bus_master.sv */
/*
 * Behavioural two-wire bus master standing on the far side of the controller.
 * Assumes the bench resolves both lines as wired-AND with pull-ups.
 */
module isc_bus_master (
	input wire logic scl, // Resolved clock line
	input wire logic sda, // Resolved data line
	output logic scl_oe, // Pull clock low
	output logic sda_oe // Pull data low
);
	timeunit 1ns;
	timeprecision 100ps;
	int stall = 0;
	initial
	begin
		scl_oe = 0;
		sda_oe = 0;
	end
	// Release SCL, then wait while any device still holds it low
	task automatic clk_hi();
		int n;
		scl_oe <= 0;
		n = 0;
		while (scl !== 1'b1 && n < 4000)
		begin
			#25;
			n++;
		end
		if (n >= 4000)
			stall++;
	endtask
	// Line changes land after a system clock edge, never racing its sampling
	task automatic start();
		sda_oe <= 1;
		#100 scl_oe <= 1;
		#100;
	endtask
	task automatic rstart();
		sda_oe <= 0;
		#100 clk_hi();
		#100 start();
	endtask
	task automatic stop();
		sda_oe <= 1;
		#100 clk_hi();
		#100 sda_oe <= 0;
		#200;
	endtask
	// Nine clocks, data moved 25 ns after the fall so it never looks like Start or Stop
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			#25 sda_oe <= ~tx[i];
			#75 clk_hi();
			#95 rx[i] = sda;
			#5 scl_oe <= 1;
		end
		#25 sda_oe <= 0;
		#300;
	endtask
endmodule // isc_bus_master

/* File: sim/test_isc_ctl.sv */
/*
 * Self-checking bench for isc_ctl: registers, slave addressing, stretching,
 * general call and master framing.
 * Assumes the bus master model isc_bus_master on the shared lines.
 */
module test_isc_ctl;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, nrst, avs_read, avs_write, scl, sda, m_scl_oe, m_sda_oe;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_v;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest, slew_control_disable, master_event_flag, slave_event_flag;
	logic [8:0] got;
	isc_pkg::isc_pad_t pad;
	int bad_count = 0;
	int check_count = 0;
	int mev = 0;
	int sev = 0;
	assign scl = ~(pad.scl_oe | m_scl_oe);
	assign sda = ~(pad.sda_oe | m_sda_oe);
	isc_ctl uut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl), .sda_i(sda),
		.pad(pad), .slew_control_disable(slew_control_disable),
		.master_event_flag(master_event_flag), .slave_event_flag(slave_event_flag));
	isc_bus_master pm (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	initial
	begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Flags are single-cycle pulses, so count them
	always @(posedge sys_clk)
	begin
		if (master_event_flag === 1'b1)
			mev <= mev + 1;
		if (slave_event_flag === 1'b1)
			sev <= sev + 1;
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One request held until waitrequest is sampled low at a rising edge
	task automatic bus(logic rd, logic [4:0] a, logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= ~rd;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0)
		begin
			bad_count++;
			finish_test();
		end
		rd_v = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask
	task automatic rchk(string nm, logic [4:0] a, logic [31:0] mask, logic [31:0] exp);
		bus(1, a, 0);
		check(nm, rd_v & mask, exp);
	endtask
	task automatic wait_mev(int target);
		int n;
		n = 0;
		while (mev < target && n < 8000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (mev < target)
		begin
			bad_count++;
			finish_test();
		end
	endtask
	initial
	begin
		nrst = 0;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		avs_byteenable = 4'h3;
		repeat (3) @(posedge sys_clk);
		nrst <= 1;
		rchk("con", 5'h08, 32'hffff, 32'h1000);
		rchk("unmapped", 5'h14, 32'hffffffff, 32'h0);
		bus(0, 5'h08, 32'h8000);
		rchk("rel kept", 5'h08, 32'h1000, 32'h1000);
		bus(0, 5'h08, 32'h9200);
		repeat (2) @(posedge sys_clk);
		check("slew", slew_control_disable, 32'h1);
		bus(0, 5'h10, 32'h52);
		bus(0, 5'h08, 32'h9040);
		pm.start();
		pm.xfer({8'ha4, 1'b1}, got);
		check("addr ack", got[0], 32'h0);
		check("slave ev", sev, 32'h1);
		rchk("rbf addr", 5'h0c, 32'h2, 32'h0);
		pm.xfer({8'h3c, 1'b1}, got);
		repeat (20) @(posedge sys_clk);
		check("rx hold", pad.scl_oe, 32'h1);
		rchk("rx rel", 5'h08, 32'h1000, 32'h0);
		rchk("rcv", 5'h00, 32'hff, 32'h3c);
		bus(0, 5'h08, 32'h9040);
		repeat (4) @(posedge sys_clk);
		check("rx free", pad.scl_oe, 32'h0);
		pm.stop();
		bus(0, 5'h08, 32'h9080);
		pm.start();
		pm.xfer({8'h00, 1'b1}, got);
		check("gc ack", got[0], 32'h0);
		check("gc ev", mev, 32'h1);
		rchk("gc rbf", 5'h0c, 32'h2, 32'h2);
		rchk("gc rcv", 5'h00, 32'hff, 32'h0);
		pm.stop();
		bus(0, 5'h08, 32'h9800);
		pm.start();
		pm.xfer({8'h10, 1'b1}, got);
		check("all ack", got[0], 32'h0);
		pm.stop();
		bus(0, 5'h08, 32'h9440);
		pm.start();
		pm.xfer({8'hf0, 1'b1}, got);
		repeat (20) @(posedge sys_clk);
		check("a10 hold", pad.scl_oe, 32'h1);
		bus(0, 5'h08, 32'h9440);
		pm.xfer({8'h52, 1'b1}, got);
		check("a10 ack", got[0], 32'h0);
		rchk("a10 full", 5'h0c, 32'h100, 32'h100);
		bus(0, 5'h08, 32'h9440);
		pm.rstart();
		pm.xfer({8'hf1, 1'b1}, got);
		repeat (20) @(posedge sys_clk);
		check("a10 tx hold", pad.scl_oe, 32'h1);
		rchk("a10 rw", 5'h0c, 32'h4, 32'h4);
		bus(0, 5'h08, 32'h9000);
		pm.stop();
		bus(0, 5'h08, 32'h9000);
		pm.start();
		pm.xfer({8'ha5, 1'b1}, got);
		repeat (20) @(posedge sys_clk);
		check("tx hold", pad.scl_oe, 32'h1);
		rchk("tx rel", 5'h08, 32'h1000, 32'h0);
		bus(0, 5'h04, 32'h96);
		bus(0, 5'h08, 32'h9000);
		pm.xfer(9'h1ff, got);
		check("tx data", got[8:1], 32'h96);
		pm.stop();
		bus(0, 5'h04, 32'h5a);
		pm.start();
		pm.xfer({8'ha5, 1'b1}, got);
		repeat (20) @(posedge sys_clk);
		check("tx no hold", pad.scl_oe, 32'h0);
		rchk("tx rel kept", 5'h08, 32'h1000, 32'h1000);
		pm.xfer(9'h1ff, got);
		check("tx preload", got[8:1], 32'h5a);
		pm.stop();
		bus(0, 5'h08, 32'h9001);
		wait_mev(2);
		check("start", {pad.sda_oe, pad.scl_oe}, 32'h3);
		bus(0, 5'h04, 32'h30);
		rchk("tx busy", 5'h0c, 32'h4001, 32'h4000);
		wait_mev(3);
		rchk("tx done", 5'h0c, 32'hc000, 32'h8000);
		bus(0, 5'h08, 32'h9004);
		wait_mev(4);
		check("stop", {pad.sda_oe, pad.scl_oe}, 32'h0);
		check("stalls", pm.stall, 32'h0);
		finish_test();
	end
endmodule // test_isc_ctl
